// ===== wdpm_pkg.sv
// Constants for the watchdog and power mode control block
package wdpm_pkg;
  // I/O addresses
  localparam logic [7:0] ADDR_MASTER   = 8'hF0;
  localparam logic [7:0] ADDR_COMMAND  = 8'hF1;
  // Command key values
  localparam logic [7:0] CMD_CLEAR     = 8'h4E;
  localparam logic [7:0] CMD_DISABLE   = 8'hB1;
  localparam logic [7:0] CMD_MODE      = 8'hDB;
  // Master register fields
  localparam int         ENABLE_POS    = 7;
  localparam int         PERIOD_HI     = 6;
  localparam int         PERIOD_LO     = 5;
  localparam int         MODE_HI       = 4;
  localparam int         MODE_LO       = 3;
  localparam logic [2:0] RSVD_VALUE    = 3'h3;
  // Reset values
  localparam logic       ENABLE_RST    = 1'h1;
  localparam logic [1:0] PERIOD_RST    = 2'h3;
  localparam logic [1:0] MODE_RST      = 2'h3;
  // Period exponents, cycles are 2 to this power
  localparam int         PERIOD_EXP0   = 16;
  localparam int         CNT_W         = 22;
  // Clock
  localparam int         CLK_PERIOD_NS = 50;
  // Power-down modes
  typedef enum logic [1:0] {
    PD_IDLE1 = 2'h0,
    PD_IDLE2 = 2'h1,
    PD_STOP  = 2'h2,
    PD_RUN   = 2'h3
  } wdpm_mode_t;
endpackage

// ===== wdpm_counter.sv
// Watchdog timeout counter with selectable period
`timescale 1ns/1ns
`default_nettype none
module wdpm_counter
  import wdpm_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Control
  input  wire logic       run,
  input  wire logic       restart,
  input  wire logic [1:0] period,
  // Status
  output logic            timeout,
  output logic [CNT_W-1:0] count
);
  logic [CNT_W-1:0] count_reg, count_next;
  logic             timeout_reg, timeout_next;
  logic [CNT_W-1:0] lastCount;

  // Terminal count is 2^(16+2*period) - 1
  function automatic logic [CNT_W-1:0] last_of(input logic [1:0] p);
    logic [CNT_W:0] one;
    one = (CNT_W+1)'(1);
    last_of = CNT_W'((one << (PERIOD_EXP0 + 2 * int'(p))) - 1);
  endfunction

  // Next count and timeout pulse
  always_comb begin
    lastCount    = last_of(period);
    count_next   = count_reg;
    timeout_next = 1'b0;
    if (restart || !run) begin
      count_next = '0;
    end else if (count_reg >= lastCount) begin
      count_next   = '0;
      timeout_next = 1'b1;
    end else begin
      count_next = count_reg + CNT_W'(1);
    end
  end

  // Registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count_reg   <= '0;
      timeout_reg <= 1'b0;
    end else begin
      count_reg   <= count_next;
      timeout_reg <= timeout_next;
    end
  end

  assign timeout = timeout_reg;
  assign count   = count_reg;
endmodule // wdpm_counter
`default_nettype wire

// ===== wdpm_key_decode.sv
// Command key decoder for the command register
`timescale 1ns/1ns
`default_nettype none
module wdpm_key_decode
  import wdpm_pkg::*;
(
  // Write strobe and data
  input  wire logic       wrCmd,
  input  wire logic [7:0] wrData,
  // Decoded commands
  output logic            cmdClear,
  output logic            cmdDisable,
  output logic            cmdMode
);
  // Unknown values decode to nothing
  always_comb begin
    cmdClear   = wrCmd && (wrData == CMD_CLEAR);
    cmdDisable = wrCmd && (wrData == CMD_DISABLE);
    cmdMode    = wrCmd && (wrData == CMD_MODE);
  end
endmodule // wdpm_key_decode
`default_nettype wire

// ===== wdpm_top.sv
// Watchdog timer and power-down mode control with two-key protection
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// - Writing the clear command restarts the watchdog period.
// - Watchdog counts until the disable command stops it, even with enable bit zero; writing one enables.
// - Disable needs enable bit zero, then the disable command.
// - Power-on reset sets the enable bit, watchdog runs.
// - Period field selects 2^16, 2^18, 2^20 or 2^22 cycles.
// - Power-on reset sets the period field to 11.
// - Mode field changes only on master write right after mode command.
// - Mode 00 idle one, 01 idle two, 10 stop, 11 run.
// - Power-on reset sets the mode field to run.
// - Low three master bits always read back as 011.
module wdpm_top
  import wdpm_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // I/O register port
  input  wire logic [7:0] ioAddr,
  input  wire logic       ioWrite,
  input  wire logic       ioRead,
  input  wire logic [7:0] ioWrData,
  output logic      [7:0] ioRdData,
  output logic            ioRdValid,
  // Watchdog and mode outputs
  output logic            watchdogTimeout,
  output logic            watchdogRunning,
  output logic      [1:0] powerDownSelect,
  output logic            modeIdle1,
  output logic            modeIdle2,
  output logic            modeStop,
  output logic            modeRun
);
  // Master register state
  logic       timerEnableBit_reg, timerEnableBit_next;
  logic       running_reg, running_next;
  logic [1:0] timeoutPeriodField_reg, timeoutPeriodField_next;
  logic [1:0] powerDownSelect_reg, powerDownSelect_next;
  logic       modeKey_reg, modeKey_next;
  logic [7:0] rdData_reg, rdData_next;
  logic       rdValid_reg, rdValid_next;
  wdpm_mode_t modeDecoded;
  // Decoded accesses
  logic       wrMaster, wrCommand;
  logic       cmdClear, cmdDisable, cmdMode;

  // Address decode
  assign wrMaster  = ioWrite && (ioAddr == ADDR_MASTER);
  assign wrCommand = ioWrite && (ioAddr == ADDR_COMMAND);

  wdpm_key_decode u_key (
    .wrCmd      (wrCommand),
    .wrData     (ioWrData),
    .cmdClear   (cmdClear),
    .cmdDisable (cmdDisable),
    .cmdMode    (cmdMode)
  );

  // Master register, keys and run state
  always_comb begin
    timerEnableBit_next     = timerEnableBit_reg;
    running_next            = running_reg;
    timeoutPeriodField_next = timeoutPeriodField_reg;
    powerDownSelect_next    = powerDownSelect_reg;
    modeKey_next            = modeKey_reg;
    if (wrMaster) begin
      timerEnableBit_next     = ioWrData[ENABLE_POS];
      if (ioWrData[ENABLE_POS]) begin
        running_next = 1'b1;
      end
      timeoutPeriodField_next = ioWrData[PERIOD_HI:PERIOD_LO];
      if (modeKey_reg) begin
        powerDownSelect_next = ioWrData[MODE_HI:MODE_LO];
      end
      modeKey_next = 1'b0;
    end else if (wrCommand) begin
      modeKey_next = cmdMode;
      if (cmdDisable && !timerEnableBit_reg) begin
        running_next = 1'b0;
      end
    end
  end

  // Master register flops
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      timerEnableBit_reg     <= ENABLE_RST;
      running_reg            <= ENABLE_RST;
      timeoutPeriodField_reg <= PERIOD_RST;
      powerDownSelect_reg    <= MODE_RST;
      modeKey_reg            <= 1'b0;
    end else begin
      timerEnableBit_reg     <= timerEnableBit_next;
      running_reg            <= running_next;
      timeoutPeriodField_reg <= timeoutPeriodField_next;
      powerDownSelect_reg    <= powerDownSelect_next;
      modeKey_reg            <= modeKey_next;
    end
  end

  wdpm_counter u_cnt (
    .clk     (clk),
    .rst     (rst),
    .run     (running_reg),
    .restart (cmdClear),
    .period  (timeoutPeriodField_reg),
    .timeout (watchdogTimeout),
    .count   ()
  );

  // Read data, command register reads as zero
  always_comb begin
    rdValid_next = ioRead;
    rdData_next  = 8'h00;
    if (ioRead && ioAddr == ADDR_MASTER) begin
      rdData_next = {timerEnableBit_reg, timeoutPeriodField_reg,
                     powerDownSelect_reg, RSVD_VALUE};
    end
  end

  // Read data flops
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdData_reg  <= 8'h00;
      rdValid_reg <= 1'b0;
    end else begin
      rdData_reg  <= rdData_next;
      rdValid_reg <= rdValid_next;
    end
  end

  assign modeDecoded     = wdpm_mode_t'(powerDownSelect_reg);
  assign modeIdle1       = (modeDecoded == PD_IDLE1);
  assign modeIdle2       = (modeDecoded == PD_IDLE2);
  assign modeStop        = (modeDecoded == PD_STOP);
  assign modeRun         = (modeDecoded == PD_RUN);
  assign powerDownSelect = powerDownSelect_reg;
  assign watchdogRunning = running_reg;
  assign ioRdData        = rdData_reg;
  assign ioRdValid       = rdValid_reg;
endmodule // wdpm_top
`default_nettype wire

// ===== wdpm_asserts.sv
// Port checker for the watchdog and power mode block
`timescale 1ns/1ns
`default_nettype none
module wdpm_asserts
  import wdpm_pkg::*;
(
  // Clock, reset and register port
  input wire logic       clk,
  input wire logic       rst,
  input wire logic [7:0] ioAddr,
  input wire logic       ioWrite,
  input wire logic       ioRead,
  input wire logic [7:0] ioWrData,
  input wire logic [7:0] ioRdData,
  input wire logic       ioRdValid,
  // Watchdog and mode outputs
  input wire logic       watchdogTimeout,
  input wire logic       watchdogRunning,
  input wire logic [1:0] powerDownSelect,
  input wire logic       modeIdle1,
  input wire logic       modeIdle2,
  input wire logic       modeStop,
  input wire logic       modeRun
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic wrMaster, wrCmd, wrOff, keyArm_reg, keyArm_next;
  // Decoded writes
  assign wrMaster = ioWrite && ioAddr == ADDR_MASTER;
  assign wrCmd    = ioWrite && ioAddr == ADDR_COMMAND;
  assign wrOff    = wrCmd && ioWrData == CMD_DISABLE;
  // Mode key: armed by the mode command, dropped by any other write to the block
  always_comb begin
    keyArm_next = keyArm_reg;
    if (wrMaster || wrCmd) begin
      keyArm_next = wrCmd && ioWrData == CMD_MODE;
    end
  end

  // Mode key flop
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      keyArm_reg <= 1'h0;
    end else begin
      keyArm_reg <= keyArm_next;
    end
  end

  a_read_answer: assert property (ioRead |=> ioRdValid)
    else $error("read not answered");
  a_rsvd_bits: assert property (
    ioRead && ioAddr == ADDR_MASTER |=> ioRdData[2:0] == RSVD_VALUE)
    else $error("reserved bits wrong");
  a_mode_decode: assert property (
    {modeIdle1, modeIdle2, modeStop, modeRun} == 4'h8 >> powerDownSelect)
    else $error("mode decode wrong");
  a_mode_locked: assert property (
    !(wrMaster && keyArm_reg) |=> $stable(powerDownSelect))
    else $error("mode changed without key");
  a_mode_update: assert property (
    wrMaster && keyArm_reg |=> powerDownSelect == $past(ioWrData[MODE_HI:MODE_LO]))
    else $error("keyed mode not taken");
  a_clear_quiet: assert property (
    wrCmd && ioWrData == CMD_CLEAR |=> !watchdogTimeout [*3])
    else $error("timeout after clear");
  a_timeout_pulse: assert property (watchdogTimeout |=> !watchdogTimeout)
    else $error("timeout longer than a cycle");
  a_timeout_runs: assert property (watchdogTimeout |-> $past(watchdogRunning))
    else $error("timeout while stopped");
  a_stop_keyed: assert property ($fell(watchdogRunning) |-> $past(wrOff))
    else $error("stopped without key");
  a_enable_runs: assert property (
    wrMaster && ioWrData[ENABLE_POS] |=> watchdogRunning)
    else $error("enable not running");
  // Main scenarios
  c_timeout: cover property (watchdogTimeout);
  c_mode: cover property (wrMaster && keyArm_reg);
  c_stop: cover property ($fell(watchdogRunning));
endmodule // wdpm_asserts
bind wdpm_top wdpm_asserts chk_u (.*);
`default_nettype wire

// ===== wdpm_top_tb.sv
// Self-checking testbench for the watchdog and power mode block
`timescale 1ns/1ns
`default_nettype none
module wdpm_top_tb
  import wdpm_pkg::*;
;
  logic       clk = 1'h0, rst = 1'h1, ioWrite = 1'h0, ioRead = 1'h0;
  logic [7:0] ioAddr = 8'h00, ioWrData = 8'h00, ioRdData;
  logic       ioRdValid, watchdogTimeout, watchdogRunning;
  logic       modeIdle1, modeIdle2, modeStop, modeRun;
  logic [1:0] powerDownSelect;
  int         fails = 0, comparisons = 0, n;
  // Rows: address, write data, expected master readback
  logic [23:0] rows [12] = '{24'hF0839B, 24'hF1DB9B, 24'hF08383, 24'hF1DB83,
    24'hF08B8B, 24'hF1DB8B, 24'hF09393, 24'hF1DB93, 24'hF09B9B, 24'hF1DB9B,
    24'hF1009B, 24'hF0839B};

  always #25 clk = ~clk;
  wdpm_top dut_u (.*);

  task automatic chk(input logic ok, input string msg);
    comparisons++;
    if (ok !== 1'h1) begin
      fails++;
      $display("ERROR %0t %s", $time, msg);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    ioAddr = a;
    ioWrData = d;
    ioWrite = 1'h1;
    @(negedge clk);
    ioWrite = 1'h0;
  endtask
  task automatic rd(input logic [7:0] e);
    @(negedge clk);
    ioAddr = ADDR_MASTER;
    ioRead = 1'h1;
    @(negedge clk);
    ioRead = 1'h0;
    chk(ioRdValid === 1'h1 && ioRdData === e, "master readback");
  endtask
  task automatic give_verdict;
    $display("fails=%0d comparisons=%0d", fails, comparisons);
    if (fails == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Watchdog: tests take about 95600 cycles, cut off at 120000
  initial begin
    #6_000_000;
    fails++;
    give_verdict;
  end

  // Main sequence
  initial begin
    repeat (12) @(negedge clk);
    rst = 1'h0;
    rd(8'hFB);
    chk(watchdogRunning === 1'h1 && modeRun === 1'h1, "reset state");
    foreach (rows[i]) begin
      wr(rows[i][23:16], rows[i][15:8]);
      rd(rows[i][7:0]);
      chk(powerDownSelect === rows[i][4:3], "mode field");
      chk({modeIdle1, modeIdle2, modeStop, modeRun} === 4'h8 >> rows[i][4:3], "decode");
    end
    // Disable needs a zero enable bit first and then the key
    wr(ADDR_COMMAND, CMD_DISABLE);
    chk(watchdogRunning === 1'h1, "unkeyed disable");
    wr(ADDR_MASTER, 8'h1B);
    wr(ADDR_COMMAND, 8'h55);
    chk(watchdogRunning === 1'h1, "lone zero enable");
    wr(ADDR_COMMAND, CMD_DISABLE);
    chk(watchdogRunning === 1'h0, "keyed disable");
    wr(ADDR_MASTER, 8'h9B);
    chk(watchdogRunning === 1'h1, "enable");
    // Mid-period clear must push the timeout a full period out
    wr(ADDR_COMMAND, CMD_CLEAR);
    repeat (30000) @(negedge clk);
    wr(ADDR_COMMAND, CMD_CLEAR);
    n = 0;
    while (watchdogTimeout !== 1'h1 && n < 70000) begin
      @(negedge clk);
      n++;
    end
    chk(n == (1 << PERIOD_EXP0), "period timeout");
    // Keyed stop mode, then a mid-run reset must bring back every default
    wr(ADDR_COMMAND, CMD_MODE);
    wr(ADDR_MASTER, 8'h13);
    chk(modeStop === 1'h1 && powerDownSelect === 2'h2, "stop mode");
    rst = 1'h1;
    repeat (12) @(negedge clk);
    rst = 1'h0;
    rd(8'hFB);
    chk(watchdogRunning === 1'h1 && modeRun === 1'h1, "reset again");
    give_verdict;
  end
endmodule // wdpm_top_tb
`default_nettype wire
